// File: core/frl_rx_pkg.sv
package frl_rx_pkg;

   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int XCVR_W          = 40;  // transceiver word
   localparam int CHAR_W          = 18;  // coded character
   localparam int SYM_W           = 16;  // decoded character
   localparam int CHARS_PER_BLOCK = 16;  // characters per clock group
   localparam int HDR_CHARS       = 4;   // packet header characters
   localparam int PIX_W           = 24;  // one pixel
   localparam int PIX_PER_BLOCK   = 8;   // pixels per clock group
   localparam int OVERSAMPLE      = 5;   // slow-rate oversampling factor
   localparam int OS_BITS         = XCVR_W / OVERSAMPLE;
   localparam int GEAR_W          = 64;  // gearbox store
   localparam int FIFO_DEPTH      = 8;
   localparam int EDID_DEPTH      = 256;
   localparam int SCDC_DEPTH      = 16;

   // ---------------------------------------------------------------
   // codes, addresses, reset values
   // ---------------------------------------------------------------
   localparam logic [1:0]  TAG_DATA      = 2'h1;
   localparam logic [1:0]  TAG_CTRL      = 2'h2;
   localparam logic [15:0] CODE_SB_START = 16'h00F0; // super_block_start_char
   localparam logic [15:0] CODE_SCR_RST  = 16'h000F; // scrambler_reset_char
   localparam logic [15:0] LFSR_SEED     = 16'hFFFF;
   localparam logic [6:0]  EDID_ADDR     = 7'h50;
   localparam logic [6:0]  SCDC_ADDR     = 7'h54;
   localparam logic [7:0]  SCDC_RESET    = 8'h00;
   localparam logic [3:0]  SCDC_CFG_IDX  = 4'h0;    // control byte
   localparam logic [3:0]  SCDC_STAT_IDX = 4'h1;    // lock status byte

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        is_ctrl;
      logic [15:0] sym;
   } frl_char_t;

   typedef struct packed {
      logic [23:0] hi;
      logic [23:0] lo;
   } pixel_pair_t;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[4] ^ s[3] ^ s[2]};
   endfunction : lfsr_next

   // take one bit of every five repeated ones
   function automatic logic [7:0] decimate(input logic [39:0] w);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < OS_BITS; i++) r[i] = w[i*OVERSAMPLE];
      return r;
   endfunction : decimate

endpackage : frl_rx_pkg

// File: core/stream_fifo.sv
`timescale 1ns/100ps
module stream_fifo
   import frl_rx_pkg::*;
#(
   parameter int WIDTH = 48,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_in,       // clock
   input  wire logic             reset_n_in,   // synced reset, low
   input  wire logic             in_valid_in,  // write offer
   input  wire logic [WIDTH-1:0] in_data_in,   // write word
   output logic                  in_ready_out, // room left
   output logic                  out_valid_out,// word present
   output logic      [WIDTH-1:0] out_data_out, // head word
   input  wire logic             out_ready_in  // drain accepts
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   // ---------------------------------------------------------------
   // pointers and fill level
   // ---------------------------------------------------------------
   always_comb begin
      push  = in_valid_in && in_ready_out;
      pop   = out_valid_out && out_ready_in;
      wr_d  = push ? wr_q + 1'b1 : wr_q;
      rd_d  = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk_in) begin
      if (push) mem_q[wr_q] <= in_data_in;
   end

   assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out  = mem_q[rd_q];

endmodule : stream_fifo

// File: core/two_wire_slave.sv
`timescale 1ns/100ps
module two_wire_slave
   import frl_rx_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = EDID_ADDR
) (
   input  wire logic       clk_in,      // clock
   input  wire logic       reset_n_in,  // synced reset, low
   input  wire logic       scl_in,      // synchronised clock line
   input  wire logic       sda_in,      // synchronised data line
   output logic            sda_oe_out,  // pull data line low
   output logic [7:0]      ptr_out,     // byte pointer
   output logic [7:0]      wdata_out,   // written byte
   output logic            we_out,      // write pulse
   input  wire logic [7:0] rdata_in     // byte at pointer
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_ADDR = 5'h02, ST_PTR = 5'h04,
      ST_WR   = 5'h08, ST_RD   = 5'h10
   } tw_state_t;

   tw_state_t  st_q, st_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   logic [3:0] cnt_q, cnt_d;
   logic       ack_q, ack_d, oe_q, oe_d, rw_q, rw_d, we_d, we_q;
   logic       scl_p_q, sda_p_q, start, stop, rise, fall;

   // ---------------------------------------------------------------
   // bus conditions and byte engine
   // ---------------------------------------------------------------
   always_comb begin
      start = scl_in && scl_p_q && sda_p_q && !sda_in;
      stop  = scl_in && scl_p_q && !sda_p_q && sda_in;
      rise  = scl_in && !scl_p_q;
      fall  = !scl_in && scl_p_q;
      st_d = st_q; sh_d = sh_q; ptr_d = ptr_q; cnt_d = cnt_q;
      ack_d = ack_q; oe_d = oe_q; rw_d = rw_q; we_d = 1'b0;
      if (start) begin
         st_d = ST_ADDR; cnt_d = '0; ack_d = 1'b0; oe_d = 1'b0;
      end else if (stop) begin
         st_d = ST_IDLE; ack_d = 1'b0; oe_d = 1'b0;
      end else if (st_q == ST_RD) begin
         if (rise && ack_q && sda_in) st_d = ST_IDLE;  // master nack
         else if (fall && ack_q) begin
            ack_d = 1'b0; sh_d = rdata_in; oe_d = !rdata_in[7];
            cnt_d = 4'h1;
         end else if (fall && cnt_q == 4'h8) begin
            oe_d = 1'b0; ack_d = 1'b1; ptr_d = ptr_q + 8'h01;
         end else if (fall) begin
            sh_d = {sh_q[6:0], 1'b0}; oe_d = !sh_q[6];
            cnt_d = cnt_q + 4'h1;
         end
      end else if (st_q != ST_IDLE) begin
         if (rise && !ack_q) begin
            sh_d = {sh_q[6:0], sda_in}; cnt_d = cnt_q + 4'h1;
         end else if (fall && ack_q) begin
            ack_d = 1'b0; oe_d = 1'b0; cnt_d = '0;
            if (st_q == ST_ADDR && rw_q) begin
               st_d = ST_RD; sh_d = rdata_in; oe_d = !rdata_in[7];
               cnt_d = 4'h1;
            end else if (st_q == ST_ADDR) st_d = ST_PTR;
            else st_d = ST_WR;
         end else if (fall && cnt_q == 4'h8) begin
            if (st_q == ST_ADDR && sh_q[7:1] != DEV_ADDR) st_d = ST_IDLE;
            else begin
               ack_d = 1'b1; oe_d = 1'b1;
               if (st_q == ST_ADDR) rw_d = sh_q[0];
               if (st_q == ST_PTR) ptr_d = sh_q;
               if (st_q == ST_WR) we_d = 1'b1;
            end
         end
      end
      if (we_q) ptr_d = ptr_q + 8'h01;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= ST_IDLE; sh_q <= '0; ptr_q <= '0; cnt_q <= '0;
         ack_q <= 1'b0; oe_q <= 1'b0; rw_q <= 1'b0; we_q <= 1'b0;
         scl_p_q <= 1'b1; sda_p_q <= 1'b1;
      end else begin
         st_q <= st_d; sh_q <= sh_d; ptr_q <= ptr_d; cnt_q <= cnt_d;
         ack_q <= ack_d; oe_q <= oe_d; rw_q <= rw_d; we_q <= we_d;
         scl_p_q <= scl_in; sda_p_q <= sda_in;
      end
   end

   assign sda_oe_out = oe_q;
   assign ptr_out    = ptr_q;
   assign wdata_out  = sh_q;
   assign we_out     = we_q;

endmodule : two_wire_slave

// File: core/sink_frl_receive_path.sv
`timescale 1ns/100ps
module sink_frl_receive_path
   import frl_rx_pkg::*;
(
   input  wire logic        clk_in,           // 20 MHz core clock
   input  wire logic        reset_n_in,       // async reset, low
   input  wire logic        link_clk_in,      // link word clock
   input  wire logic [39:0] link_word_in,     // transceiver word
   input  wire logic        oversample_en_in, // slow-rate mode
   input  wire logic        vid_ready_in,     // pixel sink ready
   output pixel_pair_t      vid_data_out,     // two pixels
   output logic             vid_valid_out,    // pixels present
   output logic [15:0]      pkt_header_out,   // first header char
   output logic             locked_out,       // link locked
   output logic             vid_lock_out,     // video locked
   output logic             overflow_out,     // words dropped
   output logic             decode_err_out,   // bad tag seen
   input  wire logic        scl_in,           // two-wire clock pin
   input  wire logic        sda_in,           // two-wire data pin
   output logic             sda_oe_out,       // data pin pulled low
   input  wire logic        edid_unlock_in,   // memory unlock
   input  wire logic [7:0]  host_addr_in,     // host memory address
   input  wire logic [7:0]  host_wdata_in,    // host write data
   input  wire logic        host_write_in,    // host write strobe
   output logic [7:0]       host_rdata_out,   // host read data
   output logic             hpd_out,          // hot-plug indicator
   output logic [7:0]       scdc_cfg_out      // control byte
);
   // ---------------------------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0]  rst_s_q;
   logic        rst_n;
   logic [1:0]  lclk_s_q, scl_s_q, sda_s_q;
   logic [39:0] word_m_q, word_s_q;
   logic        lclk_p_q;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) rst_s_q <= 2'b00;
      else rst_s_q <= {rst_s_q[0], 1'b1};
   end
   assign rst_n = rst_s_q[1];

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         lclk_s_q <= '0; scl_s_q <= 2'b11; sda_s_q <= 2'b11;
         word_m_q <= '0; word_s_q <= '0; lclk_p_q <= 1'b0;
      end else begin
         lclk_s_q <= {lclk_s_q[0], link_clk_in};
         scl_s_q  <= {scl_s_q[0], scl_in};
         sda_s_q  <= {sda_s_q[0], sda_in};
         word_m_q <= link_word_in;
         word_s_q <= word_m_q;
         lclk_p_q <= lclk_s_q[1];
      end
   end

   // ---------------------------------------------------------------
   // resampler gearbox
   // ---------------------------------------------------------------
   logic [GEAR_W-1:0] gear_q, gear_d;
   logic [6:0]        gcnt_q, gcnt_d;
   logic              ovf_q, ovf_d, take, pop;
   logic [GEAR_W-1:0] in_bits;
   logic [6:0]        in_len, after_pop;
   logic              stall;
   logic [17:0]       coded;

   // new word in on link edge, one character out per cycle
   always_comb begin
      take      = lclk_s_q[1] && !lclk_p_q;
      in_bits   = oversample_en_in
                ? {56'h0, decimate(word_s_q)} : {24'h0, word_s_q};
      in_len    = oversample_en_in ? 7'(OS_BITS) : 7'(XCVR_W);
      pop       = (gcnt_q >= 7'(CHAR_W)) && !stall;
      coded     = gear_q[CHAR_W-1:0];
      after_pop = pop ? gcnt_q - 7'(CHAR_W) : gcnt_q;
      gear_d    = pop ? gear_q >> CHAR_W : gear_q;
      gcnt_d    = after_pop;
      ovf_d     = ovf_q;
      if (take && (after_pop + in_len <= 7'(GEAR_W))) begin
         gear_d = gear_d | (in_bits << after_pop[5:0]);
         gcnt_d = after_pop + in_len;
      end else if (take) ovf_d = 1'b1;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gear_q <= '0; gcnt_q <= '0; ovf_q <= 1'b0;
      end else begin
         gear_q <= gear_d; gcnt_q <= gcnt_d; ovf_q <= ovf_d;
      end
   end

   // ---------------------------------------------------------------
   // decoder, descrambler, alignment, demapper
   // ---------------------------------------------------------------
   frl_char_t   ch;
   logic        ch_ok;
   logic [15:0] lfsr_q, lfsr_d, plain;
   logic        align_q, align_d, lock_q, lock_d, err_q, err_d;
   logic [3:0]  idx_q, idx_d;
   logic [47:0] acc_q, acc_d;
   logic [1:0]  part_q, part_d;
   logic [15:0] hdr_q, hdr_d;
   logic        push_q, push_d;
   pixel_pair_t pair_q, pair_d;
   logic        fifo_ready;

   // back-pressure: hold characters while a pair waits
   assign stall = push_q && !fifo_ready;

   always_comb begin
      ch.is_ctrl = (coded[17:16] == TAG_CTRL);
      ch.sym     = coded[15:0];
      ch_ok      = (coded[17:16] == TAG_DATA) || ch.is_ctrl;
      plain      = ch.sym ^ lfsr_q;
      lfsr_d = lfsr_q; align_d = align_q; lock_d = lock_q;
      err_d = err_q; idx_d = idx_q; acc_d = acc_q; part_d = part_q;
      hdr_d = hdr_q; pair_d = pair_q;
      push_d = push_q && !fifo_ready;
      if (pop && !ch_ok) begin
         err_d = 1'b1; align_d = 1'b0; lock_d = 1'b0;
      end else if (pop && ch.is_ctrl) begin
         if (ch.sym == CODE_SB_START || ch.sym == CODE_SCR_RST) begin
            align_d = 1'b1;
            idx_d   = '0;
            part_d  = '0;
         end
         if (ch.sym == CODE_SCR_RST) lfsr_d = LFSR_SEED;
      end else if (pop && align_q) begin
         lfsr_d = lfsr_next(lfsr_q);
         idx_d  = idx_q + 4'h1;
         if (idx_q == 4'(CHARS_PER_BLOCK - 1)) lock_d = 1'b1;
         if (idx_q == '0) hdr_d = plain;
         if (idx_q >= 4'(HDR_CHARS)) begin
            acc_d  = {acc_q[31:0], plain};
            part_d = (part_q == 2'h2) ? 2'h0 : part_q + 2'h1;
            if (part_q == 2'h2) begin
               pair_d = pixel_pair_t'({acc_q[31:0], plain});
               push_d = 1'b1;
            end
         end
      end
   end

   // lock only drops on coding faults, so blanking changes keep it
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_q <= LFSR_SEED; align_q <= 1'b0; lock_q <= 1'b0;
         err_q <= 1'b0; idx_q <= '0; acc_q <= '0; part_q <= '0;
         hdr_q <= '0; push_q <= 1'b0; pair_q <= '0;
      end else begin
         lfsr_q <= lfsr_d; align_q <= align_d; lock_q <= lock_d;
         err_q <= err_d; idx_q <= idx_d; acc_q <= acc_d;
         part_q <= part_d; hdr_q <= hdr_d; push_q <= push_d;
         pair_q <= pair_d;
      end
   end

   // ---------------------------------------------------------------
   // pixel buffer and output stage
   // ---------------------------------------------------------------
   logic        fv, fr;
   pixel_pair_t fdata, vdat_q, vdat_d;
   logic        vval_q, vval_d;

   stream_fifo #(
      .WIDTH (2 * PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_pixel_fifo (
      .clk_in        (clk_in),
      .reset_n_in    (rst_n),
      .in_valid_in   (push_q),
      .in_data_in    (pair_q),
      .in_ready_out  (fifo_ready),
      .out_valid_out (fv),
      .out_data_out  (fdata),
      .out_ready_in  (fr)
   );

   // valid marks cycles that carry pixels
   always_comb begin
      fr     = !vval_q || vid_ready_in;
      vval_d = fr ? fv : vval_q;
      vdat_d = (fr && fv) ? fdata : vdat_q;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         vval_q <= 1'b0; vdat_q <= '0;
      end else begin
         vval_q <= vval_d; vdat_q <= vdat_d;
      end
   end

   // ---------------------------------------------------------------
   // identification memory, status/control bytes, two-wire slaves
   // ---------------------------------------------------------------
   logic [7:0] edid_mem_q [EDID_DEPTH];
   logic [7:0] scdc_q [SCDC_DEPTH];
   logic [7:0] e_ptr, s_ptr, s_wdata, s_rdata, hrd_q, hrd_d;
   logic       e_oe, s_oe, s_we, oe_q, oe_d, hpd_q, hpd_d;

   two_wire_slave #(.DEV_ADDR (EDID_ADDR)) u_edid_slave (
      .clk_in     (clk_in),
      .reset_n_in (rst_n),
      .scl_in     (scl_s_q[1]),
      .sda_in     (sda_s_q[1]),
      .sda_oe_out (e_oe),
      .ptr_out    (e_ptr),
      .wdata_out  (),
      .we_out     (),
      .rdata_in   (edid_mem_q[e_ptr])
   );

   two_wire_slave #(.DEV_ADDR (SCDC_ADDR)) u_scdc_slave (
      .clk_in     (clk_in),
      .reset_n_in (rst_n),
      .scl_in     (scl_s_q[1]),
      .sda_in     (sda_s_q[1]),
      .sda_oe_out (s_oe),
      .ptr_out    (s_ptr),
      .wdata_out  (s_wdata),
      .we_out     (s_we),
      .rdata_in   (s_rdata)
   );

   // status byte mirrors lock, others are stored
   always_comb begin
      s_rdata = (s_ptr[3:0] == SCDC_STAT_IDX)
              ? {6'h0, lock_q, align_q} : scdc_q[s_ptr[3:0]];
      oe_d    = e_oe || s_oe;
      hpd_d   = !edid_unlock_in;
      hrd_d   = edid_mem_q[host_addr_in];
   end

   // host edits only while unlocked
   always_ff @(posedge clk_in) begin
      if (host_write_in && edid_unlock_in)
         edid_mem_q[host_addr_in] <= host_wdata_in;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SCDC_DEPTH; i++) scdc_q[i] <= SCDC_RESET;
         oe_q <= 1'b0; hpd_q <= 1'b0; hrd_q <= '0;
      end else begin
         if (s_we && s_ptr[3:0] != SCDC_STAT_IDX)
            scdc_q[s_ptr[3:0]] <= s_wdata;
         oe_q <= oe_d; hpd_q <= hpd_d; hrd_q <= hrd_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign vid_data_out   = vdat_q;
   assign vid_valid_out  = vval_q;
   assign pkt_header_out = hdr_q;
   assign locked_out     = lock_q;
   assign vid_lock_out   = lock_q;
   assign overflow_out   = ovf_q;
   assign decode_err_out = err_q;
   assign sda_oe_out     = oe_q;
   assign host_rdata_out = hrd_q;
   assign hpd_out        = hpd_q;
   assign scdc_cfg_out   = scdc_q[SCDC_CFG_IDX];

endmodule : sink_frl_receive_path

// File: test/frl_source_model.sv
`timescale 1ns/100ps
module frl_source_model (
   output logic        link_clk_out, // word clock, still between frames
   output logic [39:0] link_word_out // transceiver word
);
   // ---------------------------------------------
   // character serialiser
   // ---------------------------------------------
   logic bitq[$];

   // quiet line before the first frame
   initial begin
      link_clk_out = 1'b0;
      link_word_out = 40'h0;
   end

   // queue one character, bit 0 first
   task automatic put(input logic [17:0] ch);
      for (int i = 0; i < 18; i++) bitq.push_back(ch[i]);
   endtask : put

   // send queued bits as words, five copies of each bit when slow
   task automatic burst(input logic os);
      logic b;
      #10; // keep word and clock changes off the core clock edges
      while (bitq.size() > 0) begin
         for (int i = 0; i < (os ? 8 : 40); i++) begin
            b = bitq.pop_front();
            for (int k = 0; k < (os ? 5 : 1); k++)
               link_word_out[os ? i * 5 + k : i] = b;
         end
         #200 link_clk_out = 1'b1;
         #200 link_clk_out = 1'b0;
      end
      link_word_out = ~link_word_out; // stale word no longer shown
   endtask : burst
endmodule : frl_source_model

// File: test/sink_frl_receive_path_monitor.sv
`timescale 1ns/100ps
module sink_frl_receive_path_monitor
   import frl_rx_pkg::*;
(
   input wire logic        clk_in,         // core clock
   input wire logic        reset_n_in,     // async reset, low
   input wire logic        edid_unlock_in, // memory unlock
   input wire logic        host_write_in,  // host write strobe
   input wire logic [7:0]  host_addr_in,   // host address
   input wire logic [7:0]  host_wdata_in,  // host write data
   input wire logic [7:0]  host_rdata_out, // host read data
   input wire logic        hpd_out,        // hot-plug indicator
   input wire logic        vid_ready_in,   // pixel sink ready
   input wire logic        vid_valid_out,  // pixels present
   input wire pixel_pair_t vid_data_out,   // two pixels
   input wire logic        locked_out,     // link locked
   input wire logic        vid_lock_out,   // video locked
   input wire logic        decode_err_out, // bad tag seen
   input wire logic [7:0]  scdc_cfg_out    // control byte
);
   // ---------------------------------------------
   // port relations
   // ---------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   hpd_low_a: assert property (
      edid_unlock_in && $past(edid_unlock_in) |-> !hpd_out)
      else $error("hot-plug high while unlocked");
   hpd_back_a: assert property (
      $fell(edid_unlock_in) |=> hpd_out)
      else $error("hot-plug not restored");
   host_mem_a: assert property (
      $past(host_write_in && edid_unlock_in)
      && host_addr_in == $past(host_addr_in)
      |=> host_rdata_out == $past(host_wdata_in, 2))
      else $error("memory write not read back");
   lock_keep_a: assert property (
      $fell(locked_out) |-> ##[0:2] decode_err_out)
      else $error("lock lost without bad tag");
   err_unlock_a: assert property (
      $rose(decode_err_out) |-> ##[0:2] !locked_out)
      else $error("lock kept after bad tag");
   vid_lock_a: assert property (vid_lock_out == locked_out)
      else $error("video lock differs from lock");
   vid_hold_a: assert property (
      vid_valid_out && !vid_ready_in
      |=> vid_valid_out && $stable(vid_data_out))
      else $error("pixels changed while stalled");
   reset_clear_a: assert property (
      $rose(reset_n_in) |-> scdc_cfg_out == 8'h00 && !locked_out)
      else $error("state not cleared by reset");
   err_sticky_a: assert property (
      decode_err_out |=> decode_err_out)
      else $error("decode error flag not held");

   pix_c: cover property (vid_valid_out && vid_ready_in);
   lock_c: cover property ($rose(locked_out));
   unlock_c: cover property ($fell(edid_unlock_in));
endmodule : sink_frl_receive_path_monitor

bind sink_frl_receive_path sink_frl_receive_path_monitor mon_u (
   .clk_in, .reset_n_in, .edid_unlock_in, .host_write_in, .host_addr_in,
   .host_wdata_in, .host_rdata_out, .hpd_out, .vid_ready_in,
   .vid_valid_out, .vid_data_out, .locked_out, .vid_lock_out,
   .decode_err_out, .scdc_cfg_out);

// File: test/sink_frl_receive_path_tb.sv
`timescale 1ns/100ps
module sink_frl_receive_path_tb
   import frl_rx_pkg::*;
;
   // ---------------------------------------------
   // stimulus and scoreboard
   // ---------------------------------------------
   logic clk_in, reset_n_in, link_clk_in, oversample_en_in, vid_ready_in;
   logic [39:0] link_word_in;
   pixel_pair_t vid_data_out;
   logic vid_valid_out, locked_out, vid_lock_out, overflow_out;
   logic decode_err_out, sda_oe_out, edid_unlock_in, host_write_in, hpd_out;
   logic [15:0] pkt_header_out, lfsr;
   logic [7:0] host_addr_in, host_wdata_in, host_rdata_out, scdc_cfg_out, d;
   logic [47:0] exp_q[$];
   logic rdy_en;
   int seed = 97895, n_mismatch = 0, n_tests = 0, cyc = 0;
   logic scl_m = 1'b1, sda_m = 1'b1; // two-wire master levels
   wire scl_in = scl_m;
   wire sda_in = sda_m && !sda_oe_out; // pulled up unless pulled low

   frl_source_model m_u (.link_clk_out(link_clk_in),
                         .link_word_out(link_word_in));
   sink_frl_receive_path dut_u (.clk_in, .reset_n_in, .link_clk_in,
      .link_word_in, .oversample_en_in, .vid_ready_in, .vid_data_out,
      .vid_valid_out, .pkt_header_out, .locked_out, .vid_lock_out,
      .overflow_out, .decode_err_out, .scl_in, .sda_in, .sda_oe_out,
      .edid_unlock_in, .host_addr_in, .host_wdata_in, .host_write_in,
      .host_rdata_out, .hpd_out, .scdc_cfg_out);

   // 50 ns core clock
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[4] ^ s[3] ^ s[2]};
   endfunction : nxt

   task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   // one two-wire byte, last slot released for the slave acknowledge
   task automatic tw_byte(input logic [8:0] b);
      for (int i = 8; i >= 0; i--) begin
         sda_m <= b[i];
         tick(10);
         scl_m <= 1'b1;
         tick(10);
         if (i == 0) cmp(sda_oe_out, 1'b1);
         scl_m <= 1'b0;
         tick(10);
      end
   endtask : tw_byte

   // one lead character then 19 scrambled data characters
   task automatic frame(input logic [1:0] tag, input logic [15:0] code,
                        input logic os);
      logic [15:0] p, hdr;
      logic [47:0] acc;
      oversample_en_in <= os;
      if (code == CODE_SCR_RST) lfsr = LFSR_SEED;
      m_u.put({tag, code});
      for (int i = 0; i < 19; i++) begin
         p = 16'($random(seed));
         m_u.put({TAG_DATA, p ^ lfsr});
         lfsr = nxt(lfsr);
         acc = {acc[31:0], p};
         if (tag == TAG_CTRL && i > 3 && i < 16 && i % 3 == 0)
            exp_q.push_back(acc);
         if (i == 16) hdr = p;
      end
      m_u.burst(os);
      tick(40);
      if (tag == TAG_CTRL) cmp(pkt_header_out, hdr);
   endtask : frame

   // pixel checker: what stands now is taken at the next rising edge
   always @(negedge clk_in) begin
      if (vid_valid_out === 1'b1 && vid_ready_in === 1'b1)
         cmp(vid_data_out, exp_q.size() ? exp_q.pop_front() : 'x);
   end

   // stalling pixel sink and hang guard
   always @(posedge clk_in) begin
      vid_ready_in <= rdy_en && (($random(seed) & 3) != 0);
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   // main sequence
   initial begin
      {reset_n_in, oversample_en_in, edid_unlock_in, host_write_in} = '0;
      {host_addr_in, host_wdata_in, rdy_en, vid_ready_in} = '0;
      lfsr = LFSR_SEED;
      tick(12);
      reset_n_in <= 1'b1;
      tick(6);
      cmp(hpd_out, 1'b1);
      edid_unlock_in <= 1'b1;
      tick(2);
      cmp(hpd_out, 1'b0);
      d = 8'($random(seed));
      {host_addr_in, host_wdata_in, host_write_in} <= {8'h3C, d, 1'b1};
      tick(1);
      host_write_in <= 1'b0;
      tick(3);
      cmp(host_rdata_out, d);
      {edid_unlock_in, host_wdata_in, host_write_in} <= {1'b0, ~d, 1'b1};
      tick(1);
      host_write_in <= 1'b0;
      tick(3);
      cmp(host_rdata_out, d);
      cmp(hpd_out, 1'b1);
      sda_m <= 1'b0;
      tick(10);
      scl_m <= 1'b0;
      tick(10);
      tw_byte({SCDC_ADDR, 1'b0, 1'b1});
      tw_byte({4'h0, SCDC_CFG_IDX, 1'b1});
      tw_byte({d, 1'b1});
      sda_m <= 1'b0;
      tick(10);
      scl_m <= 1'b1;
      tick(10);
      sda_m <= 1'b1;
      tick(10);
      cmp(scdc_cfg_out, d);
      frame(TAG_CTRL, CODE_SB_START, 1'b0);
      frame(TAG_CTRL, CODE_SB_START, 1'b0);
      cmp(vid_valid_out, 1'b1);
      cmp({locked_out, vid_lock_out}, 2'h3);
      rdy_en <= 1'b1;
      frame(TAG_CTRL, CODE_SCR_RST, 1'b0);
      frame(TAG_CTRL, CODE_SB_START, 1'b1);
      cmp(exp_q.size(), 0);
      cmp(overflow_out, 1'b0);
      rdy_en <= 1'b0;
      frame(2'h3, 16'h0000, 1'b0);
      cmp({decode_err_out, locked_out}, 2'h2);
      reset_n_in <= 1'b0;
      tick(3);
      reset_n_in <= 1'b1;
      tick(4);
      cmp({scdc_cfg_out, decode_err_out, locked_out}, '0);
      close_out();
   end
endmodule : sink_frl_receive_path_tb
